// ### logic/tpfc_consts.svh
// Register indices, reset values, bus codes and timing figures of the pause block
`ifndef TPFC_CONSTS_SVH
`define TPFC_CONSTS_SVH
`define TPFC_MAXQ 8
`define TPFC_DATA_W 64
`define TPFC_IDX_W 12
`define TPFC_IDX_LSB 2
`define TPFC_IDX_MSB 13
`define TPFC_IDX_TX_EN 12'h605
`define TPFC_IDX_REQ 12'h606
`define TPFC_IDX_RESEND_EN 12'h607
`define TPFC_IDX_HOLDOFF 12'h608
`define TPFC_IDX_PTIME 12'h609
`define TPFC_IDX_QSEL_REACT 12'h60A
`define TPFC_IDX_RX_ACCEPT 12'h610
`define TPFC_IDX_STATUS 12'h611
`define TPFC_HOLDOFF_RST 16'hFFFF
`define TPFC_PTIME_RST 16'hFFFF
`define TPFC_QEN_RST 8'hFF
`define TPFC_RESP_OKAY 2'h0
`define TPFC_RESP_SLVERR 2'h2
`define TPFC_QUANTUM_BITS 512
`define TPFC_DP_BITS 512
`define TPFC_FIFO_DEPTH 4
`endif

// ### logic/tpfc_pause.sv
// Transmit pause and flow-control block with client FIFO and register slave
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tpfc_consts.svh"

module tpfc_fifo #(
    parameter int W = 8,
    parameter int DEPTH = `TPFC_FIFO_DEPTH
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic in_valid_in,
    input wire logic [W-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [W-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
        logic rdy;
    } tpfc_fifo_st_s;
    tpfc_fifo_st_s st, n;
    logic push, pop;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("FIFO depth must be a power of two, at least 2");
        end
    end

    always_comb begin
        n = st;
        push = in_valid_in && st.rdy;
        pop = out_ready_in && (st.cnt != '0);
        if (push) begin
            n.mem[st.wp] = in_data_in;
            n.wp = st.wp + AW'(1);
        end
        if (pop) begin
            n.rp = st.rp + AW'(1);
        end
        n.cnt = st.cnt + CW'(push) - CW'(pop);
        n.rdy = n.cnt != CW'(DEPTH);
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= '0;
        end else begin
            st <= n;
        end
    end

    assign in_ready_out = st.rdy;
    assign out_valid_out = st.cnt != '0;
    assign out_data_out = st.mem[st.rp];
endmodule

// What this block does
// - Sixteen-bit resend hold-off time, reset all ones
// - One hold-off entry per priority queue
// - Times counted in 512-bit-time quanta
// - At 100G one quantum is one cycle
// - Request is register bit OR client input
// - XOFF carries programmable pause time, reset ones
// - One pause-time entry per priority queue
// - Halt on notification only if reaction enabled
// - Receive side acts only when accept enabled
// - Matching received pause notifies transmit side
// - Accept disabled blocks every notification
// - Three-bit queue select, reset zero
// - Shared offset: reaction enable or queue select
// - Queue select steers both time tables
// - Request rise sends XOFF for that queue
// - Request fall sends XON for that queue
// - Per-queue resend enable, reset all ones
module tpfc_pause
    import tpfc_pkg::*;
#(
    parameter int NQ = 1,
    parameter bit PFC = 1'b0,
    parameter int DP_BITS = `TPFC_DP_BITS
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [15:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [15:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    input wire logic [`TPFC_MAXQ-1:0] pause_insert_in,
    input wire logic rx_pause_in,
    input wire logic [15:0] rx_pause_quanta_in,
    input wire logic cl_valid_in,
    input wire tpfc_client_s cl_word_in,
    output logic cl_ready_out,
    output logic tx_valid_out,
    output tpfc_tx_s tx_word_out,
    input wire logic tx_ready_in
);
    localparam int QUANT_CYC = `TPFC_QUANTUM_BITS / DP_BITS;
    localparam logic [15:0] TICK_LAST = 16'(QUANT_CYC - 1);
    localparam logic [`TPFC_MAXQ-1:0] QMASK = `TPFC_MAXQ'((1 << NQ) - 1);

    tpfc_state_s st, n;
    logic [`TPFC_MAXQ-1:0] req, pend;
    logic tick, can_load, pop, wr_fire, fifo_valid, qvalid;
    logic [2:0] sel;
    tpfc_client_s fifo_word;

    initial begin
        if (NQ < 1 || NQ > `TPFC_MAXQ || (!PFC && NQ != 1)) begin
            $error("Queue count out of range for this build");
        end
        if (DP_BITS != 256 && DP_BITS != 512) begin
            $error("Datapath width must be 256 or 512");
        end
    end

    tpfc_fifo #(
        .W($bits(tpfc_client_s)),
        .DEPTH(`TPFC_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .in_valid_in(cl_valid_in),
        .in_data_in(cl_word_in),
        .in_ready_out(cl_ready_out),
        .out_valid_out(fifo_valid),
        .out_data_out(fifo_word),
        .out_ready_in(pop)
    );

    function automatic logic [15:0] merge16(logic [15:0] old, logic [31:0] d, logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic [2:0] first_set(logic [`TPFC_MAXQ-1:0] v);
        first_set = 3'h0;
        for (int i = `TPFC_MAXQ - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 3'(i);
            end
        end
    endfunction

    function automatic logic [`TPFC_IDX_W-1:0] reg_idx(logic [15:0] a);
        reg_idx = (a[15:`TPFC_IDX_MSB+1] == '0) ? a[`TPFC_IDX_MSB:`TPFC_IDX_LSB] : '1;
    endfunction

    function automatic logic [33:0] rd_word(tpfc_state_s s, logic [`TPFC_IDX_W-1:0] idx,
                                            logic qv);
        rd_word = {`TPFC_RESP_OKAY, 32'h0};
        unique case (idx)
            `TPFC_IDX_TX_EN: rd_word[7:0] = s.tx_en;
            `TPFC_IDX_REQ: rd_word[7:0] = s.req_sw;
            `TPFC_IDX_RESEND_EN: rd_word[7:0] = s.resend_en;
            `TPFC_IDX_HOLDOFF: rd_word[15:0] = qv ? s.holdoff[s.qsel] : 16'h0;
            `TPFC_IDX_PTIME: rd_word[15:0] = qv ? s.ptime[s.qsel] : 16'h0;
            `TPFC_IDX_QSEL_REACT: rd_word[2:0] = PFC ? s.qsel : {2'h0, s.react_en};
            `TPFC_IDX_RX_ACCEPT: rd_word[0] = s.rx_acc_en;
            `TPFC_IDX_STATUS: rd_word[31:0] = {s.pause_cnt, 6'h0, s.in_frame,
                                               s.pause_cnt != 16'h0, s.hold_act};
            default: rd_word[33:32] = `TPFC_RESP_SLVERR;
        endcase
    endfunction

    always_comb begin
        n = st;
        req = (st.req_sw | pause_insert_in) & QMASK;
        tick = st.tick_cnt == TICK_LAST;
        n.tick_cnt = tick ? 16'h0 : st.tick_cnt + 16'h1;
        qvalid = 4'(st.qsel) < 4'(NQ);

        if (s_axi_awvalid_in && st.awready) begin
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && st.wready) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata_in;
            n.wstrb = s_axi_wstrb_in;
        end
        if (st.bvalid && s_axi_bready_in) begin
            n.bvalid = 1'b0;
        end
        wr_fire = st.aw_got && st.w_got && !st.bvalid;
        if (wr_fire) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `TPFC_RESP_OKAY;
            unique case (reg_idx(st.awaddr))
                `TPFC_IDX_TX_EN: if (st.wstrb[0]) n.tx_en = st.wdata[7:0] & QMASK;
                `TPFC_IDX_REQ: if (st.wstrb[0]) n.req_sw = st.wdata[7:0] & QMASK;
                `TPFC_IDX_RESEND_EN: if (st.wstrb[0]) n.resend_en = st.wdata[7:0] & QMASK;
                `TPFC_IDX_HOLDOFF: begin
                    if (qvalid) n.holdoff[st.qsel] = merge16(st.holdoff[st.qsel], st.wdata,
                                                             st.wstrb);
                end
                `TPFC_IDX_PTIME: begin
                    if (qvalid) n.ptime[st.qsel] = merge16(st.ptime[st.qsel], st.wdata,
                                                           st.wstrb);
                end
                `TPFC_IDX_QSEL_REACT: begin
                    if (st.wstrb[0] && PFC) n.qsel = st.wdata[2:0];
                    if (st.wstrb[0] && !PFC) n.react_en = st.wdata[0];
                end
                `TPFC_IDX_RX_ACCEPT: if (st.wstrb[0]) n.rx_acc_en = st.wdata[0];
                `TPFC_IDX_STATUS: n.bresp = `TPFC_RESP_OKAY;
                default: n.bresp = `TPFC_RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;

        if (st.rvalid && s_axi_rready_in) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && st.arready) begin
            n.rvalid = 1'b1;
            {n.rresp, n.rdata} = rd_word(st, reg_idx(s_axi_araddr_in), qvalid);
        end
        n.arready = !n.rvalid;

        for (int q = 0; q < `TPFC_MAXQ; q++) begin
            if (st.hold_act[q] && tick) begin
                if (st.hold_cnt[q] == 16'h0) begin
                    n.hold_act[q] = 1'b0;
                    if (req[q] && st.tx_en[q] && st.resend_en[q]) n.xoff_pend[q] = 1'b1;
                end else begin
                    n.hold_cnt[q] = st.hold_cnt[q] - 16'h1;
                end
            end
        end

        if (st.pause_cnt != 16'h0 && tick) begin
            n.pause_cnt = st.pause_cnt - 16'h1;
        end
        if (rx_pause_in && st.rx_acc_en && st.react_en && !PFC) begin
            n.pause_cnt = rx_pause_quanta_in;
        end

        pend = (st.xoff_pend | st.xon_pend) & st.tx_en;
        sel = first_set(pend);
        can_load = !st.out_valid || tx_ready_in;
        pop = 1'b0;
        if (can_load) begin
            n.out_valid = 1'b0;
            if (!st.in_frame && pend != '0) begin
                n.out_valid = 1'b1;
                n.out_word = '0;
                n.out_word.ctrl = 1'b1;
                n.out_word.xoff = st.xoff_pend[sel];
                n.out_word.queue = sel;
                if (st.xoff_pend[sel]) n.out_word.data[15:0] = st.ptime[sel];
                n.xoff_pend[sel] = 1'b0;
                n.xon_pend[sel] = 1'b0;
                if (st.xoff_pend[sel] && st.resend_en[sel]) begin
                    n.hold_act[sel] = 1'b1;
                    n.hold_cnt[sel] = st.holdoff[sel];
                end
            end else if (fifo_valid && (st.in_frame || st.pause_cnt == 16'h0)) begin
                pop = 1'b1;
                n.out_valid = 1'b1;
                n.out_word = '0;
                n.out_word.sop = fifo_word.sop;
                n.out_word.eop = fifo_word.eop;
                n.out_word.data = fifo_word.data;
                n.in_frame = !fifo_word.eop;
            end
        end

        for (int q = 0; q < `TPFC_MAXQ; q++) begin
            if (req[q] && !st.req_prev[q] && st.tx_en[q]) begin
                n.xoff_pend[q] = 1'b1;
                n.xon_pend[q] = 1'b0;
            end
            if (!req[q] && st.req_prev[q]) begin
                n.hold_act[q] = 1'b0;
                n.xoff_pend[q] = 1'b0;
                if (st.tx_en[q]) n.xon_pend[q] = 1'b1;
            end
        end
        n.req_prev = req;
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= '0;
            st.holdoff <= {`TPFC_MAXQ{`TPFC_HOLDOFF_RST}};
            st.ptime <= {`TPFC_MAXQ{`TPFC_PTIME_RST}};
            st.resend_en <= `TPFC_QEN_RST;
            st.tx_en <= `TPFC_QEN_RST;
        end else begin
            st <= n;
        end
    end

    assign s_axi_awready_out = st.awready;
    assign s_axi_wready_out = st.wready;
    assign s_axi_bvalid_out = st.bvalid;
    assign s_axi_bresp_out = st.bresp;
    assign s_axi_arready_out = st.arready;
    assign s_axi_rvalid_out = st.rvalid;
    assign s_axi_rdata_out = st.rdata;
    assign s_axi_rresp_out = st.rresp;
    assign tx_valid_out = st.out_valid;
    assign tx_word_out = st.out_word;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_xoff_sent;
        can_load && !st.in_frame && pend[0] && st.xoff_pend[0] && sel == 3'h0;
    endsequence
    sequence s_hold_expire;
        st.hold_act[0] && st.hold_cnt[0] == 16'h0 && tick;
    endsequence

    a_rise_sends_xoff: assert property ($rose(req[0]) && st.tx_en[0] |=> st.xoff_pend[0])
        else $error("Request rise did not arm XOFF");
    a_fall_sends_xon: assert property ($fell(req[0]) && st.tx_en[0] |=> st.xon_pend[0])
        else $error("Request fall did not arm XON");
    a_no_mid_insert: assert property (st.in_frame |=> !(st.out_valid && st.out_word.ctrl)
        || $past(can_load) && !$past(st.in_frame)) else $error("Pause word inside a frame");
    a_xoff_time_field: assert property (s_xoff_sent |=> st.out_word.xoff
        && st.out_word.data[15:0] == $past(st.ptime[0])) else $error("XOFF time field wrong");
    a_react_gate_off: assert property (rx_pause_in && !(st.rx_acc_en && st.react_en)
        && st.pause_cnt == 16'h0 |=> st.pause_cnt == 16'h0) else $error("Gated notice halted");
    a_react_load: assert property (rx_pause_in && st.rx_acc_en && st.react_en && !PFC
        |=> st.pause_cnt == $past(rx_pause_quanta_in)) else $error("Notice did not load pause");
    a_halted_no_data: assert property (st.pause_cnt != 16'h0 && !st.in_frame |-> !pop)
        else $error("Data started during remote pause");
    a_holdoff_resend: assert property (s_hold_expire ##0 req[0] && st.tx_en[0]
        && st.resend_en[0] |=> st.xoff_pend[0] && !st.hold_act[0]) else $error("No XOFF resend");
    a_holdoff_load: assert property (s_xoff_sent ##0 st.resend_en[0] && req[0]
        |=> st.hold_act[0] && st.hold_cnt[0] == $past(st.holdoff[0]))
        else $error("Hold-off not started");
endmodule

`default_nettype wire

// ### logic/tpfc_pkg.sv
// Types shared by the pause block, the link model and the bench
package tpfc_pkg;
`include "tpfc_consts.svh"
    typedef struct packed {
        logic sop;
        logic eop;
        logic [`TPFC_DATA_W-1:0] data;
    } tpfc_client_s;
    typedef struct packed {
        logic ctrl;
        logic xoff;
        logic [2:0] queue;
        logic sop;
        logic eop;
        logic [`TPFC_DATA_W-1:0] data;
    } tpfc_tx_s;
    typedef struct packed {
        logic aw_got;
        logic [15:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [`TPFC_MAXQ-1:0] tx_en;
        logic [`TPFC_MAXQ-1:0] req_sw;
        logic [`TPFC_MAXQ-1:0] resend_en;
        logic [`TPFC_MAXQ-1:0][15:0] holdoff;
        logic [`TPFC_MAXQ-1:0][15:0] ptime;
        logic react_en;
        logic [2:0] qsel;
        logic rx_acc_en;
        logic [`TPFC_MAXQ-1:0] req_prev;
        logic [`TPFC_MAXQ-1:0] xoff_pend;
        logic [`TPFC_MAXQ-1:0] xon_pend;
        logic [`TPFC_MAXQ-1:0] hold_act;
        logic [`TPFC_MAXQ-1:0][15:0] hold_cnt;
        logic [15:0] tick_cnt;
        logic [15:0] pause_cnt;
        logic in_frame;
        logic out_valid;
        tpfc_tx_s out_word;
    } tpfc_state_s;
endpackage

// ### verification/tpfc_link_model.sv
// Link-side model: downstream sink with stalls that tallies pause words
`timescale 1ns/1ns
`default_nettype none
module tpfc_link_model
    import tpfc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic tx_valid_in,
    input wire tpfc_tx_s tx_word_in,
    input wire logic stall_in,
    output logic tx_ready_out,
    output logic [7:0] xoff_cnt_out,
    output logic [7:0] xon_cnt_out,
    output logic [15:0] last_time_out,
    output logic [2:0] last_queue_out,
    output logic [7:0] frame_err_out,
    output logic [15:0] words_out
);
    logic in_frame_reg;
    logic [2:0] pat_reg;
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            {xoff_cnt_out, xon_cnt_out, last_time_out, last_queue_out} <= '0;
            {frame_err_out, words_out, in_frame_reg, pat_reg, tx_ready_out} <= '0;
        end else begin
            pat_reg <= pat_reg + 3'h1;
            tx_ready_out <= !stall_in && (pat_reg != 3'h5);
            if (tx_valid_in && tx_ready_out && tx_word_in.ctrl) begin
                // pause word inside a client frame
                if (in_frame_reg)
                    frame_err_out <= frame_err_out + 8'h1;
                if (tx_word_in.xoff) begin
                    xoff_cnt_out <= xoff_cnt_out + 8'h1;
                    last_time_out <= tx_word_in.data[15:0];
                    last_queue_out <= tx_word_in.queue;
                end else begin
                    xon_cnt_out <= xon_cnt_out + 8'h1;
                end
            end else if (tx_valid_in && tx_ready_out) begin
                words_out <= words_out + 16'h1;
                in_frame_reg <= !tx_word_in.eop;
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/tpfc_pause_test.sv
// Self-checking bench for the transmit pause block
`timescale 1ns/1ns
`default_nettype none
`include "tpfc_consts.svh"
module tpfc_pause_test
    import tpfc_pkg::*;
;
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [15:0] awaddr = '0, araddr = '0, rxq = '0;
    logic [31:0] wdata = '0, q, seed = 32'h311A741E;
    logic awready, wready, bvalid, arready, rvalid, cl_ready, tx_valid, tx_ready;
    logic stall = 1'b0, rxp = 1'b0, cl_valid = 1'b0;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, rdata2, q2;
    logic [7:0] pins = '0, xoffs, xons, ferr, x0;
    logic [15:0] ltime, words;
    logic [15:0] tq [2];
    logic [2:0] lq;
    tpfc_client_s cl_word = '0;
    tpfc_tx_s tx_word;
    int bad_count = 0, checks = 0, cyc = 0, sent = 0, s0 = 0;

    tpfc_pause #(.NQ(2), .PFC(1'b1), .DP_BITS(512)) dut_u (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .pause_insert_in(pins),
        .rx_pause_in(rxp), .rx_pause_quanta_in(rxq), .cl_valid_in(cl_valid),
        .cl_word_in(cl_word), .cl_ready_out(cl_ready), .tx_valid_out(tx_valid),
        .tx_word_out(tx_word), .tx_ready_in(tx_ready));

    tpfc_pause #(.NQ(1), .PFC(1'b0), .DP_BITS(512)) dut2_u (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(), .s_axi_awaddr_in(awaddr),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(), .s_axi_bready_in(bready),
        .s_axi_bresp_out(), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(),
        .s_axi_araddr_in(araddr), .s_axi_rvalid_out(), .s_axi_rready_in(rready),
        .s_axi_rdata_out(rdata2), .s_axi_rresp_out(), .pause_insert_in(pins),
        .rx_pause_in(rxp), .rx_pause_quanta_in(rxq), .cl_valid_in(cl_valid),
        .cl_word_in(cl_word), .cl_ready_out(), .tx_valid_out(),
        .tx_word_out(), .tx_ready_in(tx_ready));

    tpfc_link_model link_u (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .tx_valid_in(tx_valid),
        .tx_word_in(tx_word), .stall_in(stall), .tx_ready_out(tx_ready),
        .xoff_cnt_out(xoffs), .xon_cnt_out(xons), .last_time_out(ltime),
        .last_queue_out(lq), .frame_err_out(ferr), .words_out(words));

    always #2 clk_sys_in = ~clk_sys_in;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] ba(input logic [11:0] i);
        return {2'b00, i, 2'b00};
    endfunction

    function automatic logic [31:0] inr(input int v, input int lo, input int hi);
        return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
    endfunction

    task automatic summarize();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] i, input logic [31:0] d, output logic [1:0] resp);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awvalid <= 1'b1;
        awaddr <= ba(i);
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk_sys_in);
            if (awvalid && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys_in); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge clk_sys_in);
    endtask

    task automatic rd(input logic [11:0] i, output logic [31:0] d, output logic [1:0] resp);
        arvalid <= 1'b1;
        araddr <= ba(i);
        rready <= 1'b1;
        do @(posedge clk_sys_in); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_sys_in); while (rvalid !== 1'b1);
        d = rdata;
        q2 = rdata2;
        resp = rresp;
        rready <= 1'b0;
        @(posedge clk_sys_in);
    endtask

    task automatic rchk(input logic [11:0] i, input logic [31:0] exp);
        rd(i, q, r);
        chk(q, exp, "register read");
        chk(r, `TPFC_RESP_OKAY, "read response");
    endtask

    task automatic push(input logic s, input logic e);
        cl_valid <= 1'b1;
        cl_word <= '{sop: s, eop: e, data: {seed, ~seed}};
        seed = lfsr(seed);
        do @(posedge clk_sys_in); while (cl_ready !== 1'b1);
        sent++;
    endtask

    task automatic frames(input int n);
        int len;
        for (int f = 0; f < n; f++) begin
            len = 1 + seed[1:0];
            seed = lfsr(seed);
            for (int k = 0; k < len; k++)
                push(k == 0, k == len - 1);
        end
        cl_valid <= 1'b0;
    endtask

    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        repeat (6) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        @(posedge clk_sys_in);
        rchk(`TPFC_IDX_HOLDOFF, 32'hFFFF); // hold-off reset
        rchk(`TPFC_IDX_PTIME, 32'hFFFF); // pause time reset
        rchk(`TPFC_IDX_QSEL_REACT, 32'h0); // queue select reset
        rchk(`TPFC_IDX_RESEND_EN, {24'h0, `TPFC_QEN_RST}); // resend enable reset
        rd(12'h7FF, q, r);
        chk(r, `TPFC_RESP_SLVERR, "unmapped read"); // offset decode
        wr(12'h7FE, 32'h1, r);
        chk(r, `TPFC_RESP_SLVERR, "unmapped write"); // offset decode
        for (int n = 1; n >= 0; n--) begin
            wr(`TPFC_IDX_QSEL_REACT, n, r);
            tq[n] = seed[15:0] | 16'h0100;
            seed = lfsr(seed);
            wr(`TPFC_IDX_PTIME, tq[n], r);
            wr(`TPFC_IDX_HOLDOFF, ~tq[n], r);
        end
        rchk(`TPFC_IDX_QSEL_REACT, 32'h0); // queue select readback
        for (int n = 0; n < 2; n++) begin
            wr(`TPFC_IDX_QSEL_REACT, n, r);
            rchk(`TPFC_IDX_PTIME, tq[n]); // pause table entry
            rchk(`TPFC_IDX_HOLDOFF, {16'h0, ~tq[n]}); // hold-off table entry
            wr(`TPFC_IDX_HOLDOFF, n ? 32'hFFFF : 32'h3, r);
        end
        fork
            frames(6);
            begin
                pins[1] <= 1'b1;
                repeat (80) @(posedge clk_sys_in);
            end
        join
        chk(xoffs, 8'h1, "xoff count"); // single xoff on long hold-off
        chk(lq, 3'h1, "xoff queue"); // queue id
        chk(ltime, tq[1], "xoff time"); // programmed time
        pins[1] <= 1'b0;
        repeat (40) @(posedge clk_sys_in);
        chk(xons, 8'h1, "xon count"); // xon on fall
        chk(ferr, 8'h0, "pause inside frame"); // boundary only
        chk(words, sent, "client words"); // no client word lost
        wr(`TPFC_IDX_REQ, 32'h1, r);
        repeat (60) @(posedge clk_sys_in);
        chk(inr(xoffs, 7, 17), 32'h1, "resend count"); // resend period
        chk(lq, 3'h0, "resend queue"); // queue id
        wr(`TPFC_IDX_REQ, 32'h0, r);
        repeat (20) @(posedge clk_sys_in);
        chk(xons, 8'h2, "xon after register"); // xon on fall
        wr(`TPFC_IDX_RESEND_EN, 32'h2, r);
        x0 = xoffs;
        wr(`TPFC_IDX_REQ, 32'h1, r);
        repeat (60) @(posedge clk_sys_in);
        chk(xoffs, x0 + 8'h1, "no resend"); // resend gated
        wr(`TPFC_IDX_REQ, 32'h0, r);
        wr(`TPFC_IDX_RESEND_EN, 32'h3, r);
        rxq <= 16'h0040;
        rxp <= 1'b1;
        @(posedge clk_sys_in);
        rxp <= 1'b0;
        @(posedge clk_sys_in);
        rd(`TPFC_IDX_STATUS, q, r);
        chk(q[8], 1'b0, "remote pause with accept off"); // notification blocked
        chk(q2[8], 1'b0, "standard build accept off"); // notification blocked
        wr(`TPFC_IDX_RX_ACCEPT, 32'h1, r);
        rxp <= 1'b1;
        @(posedge clk_sys_in);
        rxp <= 1'b0;
        rd(`TPFC_IDX_STATUS, q, r);
        chk(q2[8], 1'b1, "standard build remote pause"); // notification halts
        chk(inr(q2[31:16], 56, 64), 32'h1, "remote quanta"); // quantum per cycle
        chk(q[8], 1'b0, "priority build ignores notice"); // standard mode only
        s0 = sent;
        stall <= 1'b1;
        fork
            begin
                for (int k = 0; k < 8; k++)
                    push(k == 0, k == 7);
                cl_valid <= 1'b0;
            end
            begin
                repeat (30) @(posedge clk_sys_in);
                chk(cl_ready, 1'b0, "full buffer ready"); // stream held intact
                chk(inr(sent - s0, 4, 6), 32'h1, "buffer fill"); // stream held intact
                stall <= 1'b0;
            end
        join
        repeat (40) @(posedge clk_sys_in);
        chk(words, sent, "drained words"); // stream intact
        chk(ferr, 8'h0, "pause inside frame"); // boundary only
        summarize();
    end
endmodule
`default_nettype wire
